// ===== ebs_strobe_unit.sv
// Purpose: bus state sequencing and active-low strobes of the external memory bus
// Assumes: core requests come from logic on clk; hold and self-refresh pins are async
// Notes: bus clock is divided from clk; bus states change on its rising edge, store strobe edges follow its falling edge
`timescale 1ns/1ns

module ebs_strobe_unit #(
    parameter int HALF = ebs_pkg::EBS_BUS_CLOCK_OUT_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire ebs_pkg::ebs_req_type core_req,
    output logic core_req_done,
    input wire logic internal_refresh_req,
    input wire logic standby_in,
    output logic external_access_stall,
    input wire logic bus_hold_request,
    output logic bus_hold_acknowledge,
    input wire logic self_refresh_request_in,
    output logic refresh_request_out,
    output logic sdram_clock_enable,
    output logic [ebs_pkg::EBS_CTRL_W-1:0] ctrl_pin_o,
    output logic [ebs_pkg::EBS_CTRL_W-1:0] ctrl_pin_oe,
    output logic [ebs_pkg::EBS_SEL_W-1:0] select_pin_o,
    output logic [ebs_pkg::EBS_SEL_W-1:0] select_pin_oe,
    output logic [ebs_pkg::EBS_SD_W-1:0] sdram_pin_o,
    output logic [ebs_pkg::EBS_SD_W-1:0] sdram_pin_oe
);
    localparam int A_BUSP_M1 = 2 * HALF - 1;
    localparam int A_HOLD_MAX = 6 * HALF;

    typedef struct packed {
        logic hold_s1;
        logic hold_s2;
        logic self_s1;
        logic self_s2;
        ebs_pkg::ebs_bus_state_type bus_state;
        logic [7:0] div;
        logic bus_clock_out;
        ebs_pkg::ebs_req_type cur;
        logic refresh_pend;
        logic [3:0] lane_wr;
        logic wr_act;
        logic [15:0] ctrl_fn;
        logic [15:0] ctrl_dir;
        logic [9:0] sel_fn;
        logic [9:0] sel_dir;
        logic [3:0] sd_fn;
        logic [3:0] sd_dir;
        logic [31:0] port_data;
        logic io_strobe_always_enable;
        logic [15:0] ctl;
        logic [9:0] sel;
        logic [3:0] sd;
        logic [15:0] ctrl_o;
        logic [15:0] ctrl_oe;
        logic [9:0] sel_o;
        logic [9:0] sel_oe;
        logic [3:0] sd_o;
        logic [3:0] sd_oe;
        logic refresh_out;
        logic hold_ack;
        logic cke;
        logic done;
        logic stall;
        logic ack;
        logic [31:0] dat;
    } ebs_state_type;

    ebs_state_type q;
    ebs_state_type n;
    logic rst_s1;
    logic rst_n_sync;

    // reset release through two flops; assertion is immediate
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1 <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n_sync <= rst_s1;
        end
    end

    // next-state logic for the whole unit
    always_comb begin
        logic rise;
        logic fall;
        logic ext_area;
        logic wr_cyc;
        logic rd_cyc;
        logic sd_cyc;
        logic active;
        logic io_ok;
        logic [31:0] rd;
        n = q;
        rise = 1'b0;
        fall = 1'b0;
        ext_area = 1'b0;
        wr_cyc = 1'b0;
        rd_cyc = 1'b0;
        sd_cyc = 1'b0;
        active = 1'b0;
        io_ok = 1'b0;
        rd = 32'h0000_0000;
        // pin synchronisers; first stage feeds only the second
        n.hold_s1 = bus_hold_request;
        n.hold_s2 = q.hold_s1;
        n.self_s1 = self_refresh_request_in;
        n.self_s2 = q.self_s1;
        if (q.div == 8'(HALF - 1)) begin
            n.div = 8'h00;
            n.bus_clock_out = ~q.bus_clock_out;
            rise = ~q.bus_clock_out;
            fall = q.bus_clock_out;
        end else begin
            n.div = q.div + 8'h01;
        end
        // refresh request is sticky; a new request wins over the clear
        n.refresh_pend = q.refresh_pend | internal_refresh_req;
        n.done = 1'b0;
        // bus state sequencing, one state per bus clock
        if (rise) begin
            unique case (q.bus_state)
                // first decision after reset looks at the self-refresh pin
                ebs_pkg::EBS_BOOT: begin
                    n.bus_state = q.self_s2 ? ebs_pkg::EBS_IDLE : ebs_pkg::EBS_SELF;
                end
                ebs_pkg::EBS_IDLE, ebs_pkg::EBS_T2, ebs_pkg::EBS_REF2: begin
                    n.done = (q.bus_state == ebs_pkg::EBS_T2);
                    // hold is taken only between cycles
                    if (q.hold_s2) begin
                        n.bus_state = ebs_pkg::EBS_HOLD;
                    end else if (!q.self_s2) begin
                        n.bus_state = ebs_pkg::EBS_SELF;
                    end else if (q.refresh_pend) begin
                        n.bus_state = ebs_pkg::EBS_REF1;
                        n.refresh_pend = internal_refresh_req;
                    end else if (core_req.valid && q.bus_state != ebs_pkg::EBS_T2) begin
                        n.bus_state = ebs_pkg::EBS_T1;
                        n.cur = core_req;
                    end else begin
                        n.bus_state = ebs_pkg::EBS_IDLE;
                    end
                end
                ebs_pkg::EBS_T1: n.bus_state = ebs_pkg::EBS_T2;
                ebs_pkg::EBS_REF1: n.bus_state = ebs_pkg::EBS_REF2;
                ebs_pkg::EBS_HOLD: begin
                    n.bus_state = q.hold_s2 ? ebs_pkg::EBS_HOLD : ebs_pkg::EBS_IDLE;
                end
                // self-refresh holds the bus until the pin is released
                ebs_pkg::EBS_SELF: begin
                    n.bus_state = q.self_s2 ? ebs_pkg::EBS_IDLE : ebs_pkg::EBS_SELF;
                end
            endcase
        end
        // classification of the cycle being run
        active = (n.bus_state == ebs_pkg::EBS_T1) || (n.bus_state == ebs_pkg::EBS_T2);
        sd_cyc = active && (n.cur.area == ebs_pkg::EBS_AREA_SDRAM);
        ext_area = active && !sd_cyc;
        wr_cyc = ext_area && n.cur.write && (n.cur.area != ebs_pkg::EBS_AREA_PAGEROM);
        rd_cyc = ext_area && !n.cur.write;
        io_ok = n.cur.flyby || (n.cur.area == ebs_pkg::EBS_AREA_SRAM) ||
            (q.io_strobe_always_enable && (n.cur.area != ebs_pkg::EBS_AREA_PAGEROM));
        // lane strobes switch on bus clock falling edges only
        if (fall) begin
            if (q.bus_state == ebs_pkg::EBS_T1 && wr_cyc) begin
                n.wr_act = 1'b1;
                n.lane_wr = q.cur.lanes;
            end else if (q.bus_state == ebs_pkg::EBS_T2) begin
                n.wr_act = 1'b0;
                n.lane_wr = 4'h0;
            end
        end
        // all control strobes active low, built as inverted enables
        // one store strobe per written lane
        n.ctl[ebs_pkg::EBS_CTRL_STORE_LSB +: 4] = ~n.lane_wr;
        // byte enables follow the lanes of any active cycle
        n.ctl[ebs_pkg::EBS_CTRL_BE_LSB +: 4] = active ? ~n.cur.lanes : 4'hf;
        // masks low on unused sdram lanes, high outside sdram cycles
        n.ctl[ebs_pkg::EBS_CTRL_DQM_LSB +: 4] = sd_cyc ? n.cur.lanes : 4'hf;
        // load strobe for external reads, idle inactive
        n.ctl[ebs_pkg::EBS_CTRL_LOAD_STROBE] = ~rd_cyc;
        // common store strobe shares the lane strobe timing
        n.ctl[ebs_pkg::EBS_CTRL_STORE_STROBE] = ~n.wr_act;
        n.ctl[ebs_pkg::EBS_CTRL_SDRAM_WE] = ~(sd_cyc && n.cur.write);
        // start flag for the first bus clock of a cycle
        n.ctl[ebs_pkg::EBS_CTRL_CYCLE_START_FLAG] = ~(n.bus_state == ebs_pkg::EBS_T1);
        // one block select per memory block
        for (int i = 0; i < 8; i++) begin
            n.sel[i] = ~(ext_area && (n.cur.block == 3'(i)));
        end
        n.sel[ebs_pkg::EBS_SEL_FLYBY_STORE] = ~(ext_area && n.cur.write && io_ok);
        n.sel[ebs_pkg::EBS_SEL_FLYBY_LOAD] = ~(ext_area && !n.cur.write && io_ok);
        // clock enable drops in self-refresh or standby
        n.cke = !(n.bus_state == ebs_pkg::EBS_SELF || standby_in);
        // row strobe in T1 and REF1, column strobe in T2 and REF1
        n.sd[ebs_pkg::EBS_SD_CLOCK_ENABLE] = n.cke;
        n.sd[ebs_pkg::EBS_SD_BUS_CLOCK] = n.bus_clock_out;
        n.sd[ebs_pkg::EBS_SD_ROW_STROBE] = !((sd_cyc && n.bus_state == ebs_pkg::EBS_T1) ||
            n.bus_state == ebs_pkg::EBS_REF1);
        n.sd[ebs_pkg::EBS_SD_COLUMN_STROBE] = !((sd_cyc && n.bus_state == ebs_pkg::EBS_T2) ||
            n.bus_state == ebs_pkg::EBS_REF1);
        n.hold_ack = (n.bus_state == ebs_pkg::EBS_HOLD);
        // low through the refresh cycle so decoders can gate row strobes
        // while held, a pending refresh is shown to the external master
        n.refresh_out = !((n.bus_state == ebs_pkg::EBS_REF1) ||
            (n.bus_state == ebs_pkg::EBS_REF2) || (n.hold_ack && n.refresh_pend));
        // peripheral and external access waits out self-refresh
        n.stall = (n.bus_state == ebs_pkg::EBS_SELF) || (n.bus_state == ebs_pkg::EBS_BOOT);
        // per-bit port or control function; control pins float in hold except sdram clock enable and bus clock
        n.ctrl_o = (q.ctrl_fn & n.ctl) | (~q.ctrl_fn & q.port_data[ebs_pkg::EBS_PD_CTRL_LSB +: 16]);
        n.ctrl_oe = (q.ctrl_fn & {16{~n.hold_ack}}) | (~q.ctrl_fn & q.ctrl_dir);
        n.sel_o = (q.sel_fn & n.sel) | (~q.sel_fn & q.port_data[ebs_pkg::EBS_PD_SEL_LSB +: 10]);
        n.sel_oe = (q.sel_fn & {10{~n.hold_ack}}) | (~q.sel_fn & q.sel_dir);
        n.sd_o = (q.sd_fn & n.sd) | (~q.sd_fn & q.port_data[ebs_pkg::EBS_PD_SD_LSB +: 4]);
        n.sd_oe = (q.sd_fn & ~(ebs_pkg::EBS_SD_HOLD_FLOAT & {4{n.hold_ack}})) |
            (~q.sd_fn & q.sd_dir);
        // wishbone slave: ack one cycle after the request, write on the acked edge
        n.ack = wb_cyc_i && wb_stb_i && !q.ack;
        if (wb_cyc_i && wb_stb_i && wb_we_i && q.ack) begin
            unique case (wb_adr_i)
                ebs_pkg::EBS_ADDR_CTRL_FN: n.ctrl_fn = wb_dat_i[15:0];
                ebs_pkg::EBS_ADDR_CTRL_DIR: n.ctrl_dir = wb_dat_i[15:0];
                ebs_pkg::EBS_ADDR_SEL_FN: n.sel_fn = wb_dat_i[9:0];
                ebs_pkg::EBS_ADDR_SEL_DIR: n.sel_dir = wb_dat_i[9:0];
                ebs_pkg::EBS_ADDR_SD_FN: n.sd_fn = wb_dat_i[3:0];
                ebs_pkg::EBS_ADDR_SD_DIR: n.sd_dir = wb_dat_i[3:0];
                ebs_pkg::EBS_ADDR_BCP: n.io_strobe_always_enable = wb_dat_i[ebs_pkg::EBS_BCP_IO_STROBE_ALWAYS_ENABLE_BIT];
                ebs_pkg::EBS_ADDR_PORT_DATA: begin
                    for (int b = 0; b < 4; b++) begin
                        if (wb_sel_i[b]) begin
                            n.port_data[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                        end
                    end
                end
                default: ;
            endcase
        end
        // read mux; unmapped offsets read zero
        unique case (wb_adr_i)
            ebs_pkg::EBS_ADDR_CTRL_FN: rd = {16'h0000, q.ctrl_fn};
            ebs_pkg::EBS_ADDR_CTRL_DIR: rd = {16'h0000, q.ctrl_dir};
            ebs_pkg::EBS_ADDR_SEL_FN: rd = {22'h000000, q.sel_fn};
            ebs_pkg::EBS_ADDR_SEL_DIR: rd = {22'h000000, q.sel_dir};
            ebs_pkg::EBS_ADDR_SD_FN: rd = {28'h0000000, q.sd_fn};
            ebs_pkg::EBS_ADDR_SD_DIR: rd = {28'h0000000, q.sd_dir};
            ebs_pkg::EBS_ADDR_BCP: rd = {31'h00000000, q.io_strobe_always_enable};
            ebs_pkg::EBS_ADDR_PORT_DATA: rd = q.port_data;
            ebs_pkg::EBS_ADDR_STATUS: rd = {24'h000000, q.refresh_pend, q.cke, q.hold_ack,
                q.stall, 1'b0, q.bus_state};
            default: rd = 32'h0000_0000;
        endcase
        n.dat = n.ack ? rd : 32'h0000_0000;
    end

    // single state register; internal strobes reset inactive (high), pin vector outputs and enables reset low
    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            q <= '0;
            q.self_s1 <= 1'b1;
            q.self_s2 <= 1'b1;
            q.bus_state <= ebs_pkg::EBS_BOOT;
            q.ctrl_fn <= ebs_pkg::EBS_CTRL_FN_RST;
            q.sel_fn <= ebs_pkg::EBS_SEL_FN_RST;
            q.sd_fn <= ebs_pkg::EBS_SD_FN_RST;
            q.ctl <= '1;
            q.sel <= '1;
            q.sd <= 4'hd;
            q.refresh_out <= 1'b1;
            q.cke <= 1'b1;
            q.stall <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;
    assign core_req_done = q.done;
    assign external_access_stall = q.stall;
    assign bus_hold_acknowledge = q.hold_ack;
    assign refresh_request_out = q.refresh_out;
    assign sdram_clock_enable = q.cke;
    assign ctrl_pin_o = q.ctrl_o;
    assign ctrl_pin_oe = q.ctrl_oe;
    assign select_pin_o = q.sel_o;
    assign select_pin_oe = q.sel_oe;
    assign sdram_pin_o = q.sd_o;
    assign sdram_pin_oe = q.sd_oe;

    // a strobe that falls stays low exactly one bus clock period
    sequence s_low_one_period(x);
        ##A_BUSP_M1 !x ##1 x;
    endsequence

    property p_start_one_clock;
        @(posedge clk) disable iff (!rst_n_sync)
        $fell(q.ctl[ebs_pkg::EBS_CTRL_CYCLE_START_FLAG]) |->
            s_low_one_period(q.ctl[ebs_pkg::EBS_CTRL_CYCLE_START_FLAG]);
    endproperty
    a_start_one_clock: assert property (p_start_one_clock) else $error("start flag width");

    property p_store_fall_timing;
        @(posedge clk) disable iff (!rst_n_sync)
        $fell(q.ctl[ebs_pkg::EBS_CTRL_STORE_STROBE]) |->
            $past(q.bus_state) == ebs_pkg::EBS_T1 && !q.bus_clock_out
            ##0 s_low_one_period(q.ctl[ebs_pkg::EBS_CTRL_STORE_STROBE]);
    endproperty
    a_store_fall_timing: assert property (p_store_fall_timing) else $error("store strobe timing");

    property p_lane_matches_common;
        @(posedge clk) disable iff (!rst_n_sync)
        (q.ctl[ebs_pkg::EBS_CTRL_STORE_LSB +: 4] != 4'hf) |->
            !q.ctl[ebs_pkg::EBS_CTRL_STORE_STROBE] && q.cur.write;
    endproperty
    a_lane_matches_common: assert property (p_lane_matches_common) else $error("lane strobe");

    property p_idle_quiet;
        @(posedge clk) disable iff (!rst_n_sync)
        (q.bus_state == ebs_pkg::EBS_IDLE && q.wr_act == 1'b0) |-> (&q.ctl) && (&q.sel);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("strobe active in idle");

    property p_one_block;
        @(posedge clk) disable iff (!rst_n_sync)
        (q.sel[7:0] != 8'hff) |-> $onehot0(~q.sel[7:0]) &&
            (q.bus_state == ebs_pkg::EBS_T1 || q.bus_state == ebs_pkg::EBS_T2);
    endproperty
    a_one_block: assert property (p_one_block) else $error("block select");

    property p_refresh_out;
        @(posedge clk) disable iff (!rst_n_sync)
        (q.bus_state == ebs_pkg::EBS_REF1) |-> !q.refresh_out ##1 !q.refresh_out[*1];
    endproperty
    a_refresh_out: assert property (p_refresh_out) else $error("refresh output");

    property p_hold_refresh;
        @(posedge clk) disable iff (!rst_n_sync)
        (q.hold_ack && q.refresh_pend) |-> !q.refresh_out;
    endproperty
    a_hold_refresh: assert property (p_hold_refresh) else $error("refresh in hold");

    property p_self_cke;
        @(posedge clk) disable iff (!rst_n_sync)
        (q.bus_state == ebs_pkg::EBS_SELF) |-> !q.cke && q.stall;
    endproperty
    a_self_cke: assert property (p_self_cke) else $error("cke in self-refresh");

    property p_hold_ack_time;
        @(posedge clk) disable iff (!rst_n_sync)
        (q.hold_s2 && q.bus_state == ebs_pkg::EBS_IDLE && !q.refresh_pend) |->
            ##[1:A_HOLD_MAX] q.hold_ack;
    endproperty
    a_hold_ack_time: assert property (p_hold_ack_time) else $error("hold not acknowledged");

    property p_hold_float;
        @(posedge clk) disable iff (!rst_n_sync)
        q.hold_ack |-> ((q.ctrl_oe & q.ctrl_fn) == 16'h0000) && ((q.sel_oe & q.sel_fn) == 10'h000);
    endproperty
    a_hold_float: assert property (p_hold_float) else $error("pins driven in hold");
endmodule

// ===== ebs_pkg.sv
// Purpose: shared constants and types of the external bus strobe unit
// Assumes: 32-bit classic wishbone register port, word aligned offsets
// Notes: control pins are active low; pin vector bit positions are named here
package ebs_pkg;
    // timing: core clock and bus clock periods in ns
    localparam int EBS_CLK_PERIOD_NS = 4;
    localparam int EBS_BUS_CLOCK_OUT_PERIOD_NS = 48;
    localparam int EBS_BUS_CLOCK_OUT_HALF_CYCLES = EBS_BUS_CLOCK_OUT_PERIOD_NS / (2 * EBS_CLK_PERIOD_NS);

    // register byte offsets
    localparam logic [7:0] EBS_ADDR_CTRL_FN = 8'h00;
    localparam logic [7:0] EBS_ADDR_CTRL_DIR = 8'h04;
    localparam logic [7:0] EBS_ADDR_SEL_FN = 8'h08;
    localparam logic [7:0] EBS_ADDR_SEL_DIR = 8'h0c;
    localparam logic [7:0] EBS_ADDR_SD_FN = 8'h10;
    localparam logic [7:0] EBS_ADDR_SD_DIR = 8'h14;
    localparam logic [7:0] EBS_ADDR_BCP = 8'h18;
    localparam logic [7:0] EBS_ADDR_PORT_DATA = 8'h1c;
    localparam logic [7:0] EBS_ADDR_STATUS = 8'h20;

    // bus cycle period control field
    localparam int EBS_BCP_IO_STROBE_ALWAYS_ENABLE_BIT = 0;
    // port data register layout
    localparam int EBS_PD_CTRL_LSB = 0;
    localparam int EBS_PD_SEL_LSB = 16;
    localparam int EBS_PD_SD_LSB = 26;

    // control pin group: lanes 0..3 store strobes, byte enables, data masks
    localparam int EBS_CTRL_W = 16;
    localparam int EBS_CTRL_STORE_LSB = 0;
    localparam int EBS_CTRL_BE_LSB = 4;
    localparam int EBS_CTRL_DQM_LSB = 8;
    localparam int EBS_CTRL_LOAD_STROBE = 12;
    localparam int EBS_CTRL_STORE_STROBE = 13;
    localparam int EBS_CTRL_SDRAM_WE = 14;
    localparam int EBS_CTRL_CYCLE_START_FLAG = 15;
    // select pin group: block selects 0..7 then flyby strobes
    localparam int EBS_SEL_W = 10;
    localparam int EBS_SEL_FLYBY_STORE = 8;
    localparam int EBS_SEL_FLYBY_LOAD = 9;
    // sdram pin group
    localparam int EBS_SD_W = 4;
    localparam int EBS_SD_CLOCK_ENABLE = 0;
    localparam int EBS_SD_BUS_CLOCK = 1;
    localparam int EBS_SD_COLUMN_STROBE = 2;
    localparam int EBS_SD_ROW_STROBE = 3;
    localparam logic [3:0] EBS_SD_HOLD_FLOAT = 4'hc;

    // reset values
    localparam logic [15:0] EBS_CTRL_FN_RST = 16'h0000;
    localparam logic [9:0] EBS_SEL_FN_RST = 10'h000;
    localparam logic [3:0] EBS_SD_FN_RST = 4'h0;

    typedef enum logic [2:0] {
        EBS_AREA_SRAM, EBS_AREA_ROM, EBS_AREA_IO, EBS_AREA_PAGEROM, EBS_AREA_SDRAM
    } ebs_area_type;

    typedef enum logic [2:0] {
        EBS_BOOT, EBS_IDLE, EBS_T1, EBS_T2, EBS_REF1, EBS_REF2, EBS_HOLD, EBS_SELF
    } ebs_bus_state_type;

    // bus cycle request from the core
    typedef struct packed {
        logic valid;
        logic write;
        ebs_area_type area;
        logic [2:0] block;
        logic [3:0] lanes;
        logic flyby;
    } ebs_req_type;
endpackage

// ===== ebs_far_side.sv
// Purpose: far side model: an external bus master and the self-refresh source
// Assumes: the bench commands it on clk
// Notes: self-refresh pin idles high as if pulled up
`timescale 1ns/1ns
module ebs_far_side (
    input wire logic clk,
    input wire logic hold_want,
    input wire logic self_want,
    input wire logic bus_hold_acknowledge,
    output logic bus_hold_request,
    output logic self_refresh_request_in
);
    initial bus_hold_request = 1'b0;
    // hold until granted
    // an early drop would leave the grant unsafe, so keep asking until acknowledged
    always @(posedge clk) begin
        bus_hold_request <= hold_want | (bus_hold_request & ~bus_hold_acknowledge);
    end
    // pull-up keeps the pin high unless self-refresh is wanted
    assign self_refresh_request_in = ~self_want;
endmodule

// ===== external_bus_strobe_unit_test.sv
// Purpose: self-checking bench of the external bus strobe unit
// Assumes: default bus clock divider, pins in control mode after setup
// Notes: bus cycles are judged by which active-low pins went low at all
`timescale 1ns/1ns
module external_bus_strobe_unit_test;
    logic clk = 0, nrst = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0, irq_ref = 0, standby = 0;
    logic hold_want = 0, self_want = 1, hreq, hack, self_n, rr, cke, stall, done, ack, rl;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] sd_o, sd_oe, sdl;
    logic [9:0] sel_o, sel_oe;
    logic [15:0] ctrl_o, ctrl_oe;
    logic [31:0] wb_dat = 32'h0, rd_q, q;
    ebs_pkg::ebs_req_type core_req = '0;
    int fails = 0, checks_done = 0, cycles = 0;
    always #2 clk = ~clk;
    ebs_strobe_unit dut_u (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
        .wb_dat_o(rd_q), .wb_ack_o(ack), .core_req(core_req), .core_req_done(done),
        .internal_refresh_req(irq_ref), .standby_in(standby), .external_access_stall(stall),
        .bus_hold_request(hreq), .bus_hold_acknowledge(hack), .self_refresh_request_in(self_n),
        .refresh_request_out(rr), .sdram_clock_enable(cke), .ctrl_pin_o(ctrl_o),
        .ctrl_pin_oe(ctrl_oe), .select_pin_o(sel_o), .select_pin_oe(sel_oe),
        .sdram_pin_o(sd_o), .sdram_pin_oe(sd_oe));
    ebs_far_side far_u (.clk(clk), .hold_want(hold_want), .self_want(self_want),
        .bus_hold_acknowledge(hack), .bus_hold_request(hreq), .self_refresh_request_in(self_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one classic cycle: request held until ack, data taken at that edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rd_q;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask
    // one core bus cycle; gathers every pin seen low, ignoring the masked bits
    task automatic bus(input ebs_pkg::ebs_req_type r, input logic [15:0] ec, ic,
        input logic [9:0] es, is, input logic [3:0] ed);
        logic [15:0] lc;
        logic [9:0] ls;
        logic [3:0] ld;
        int nd;
        lc = '0;
        ls = '0;
        ld = '0;
        nd = 0;
        core_req <= r;
        for (int i = 0; i < 44; i++) begin
            @(posedge clk);
            if (done === 1'b1) core_req <= '0;
            nd += (done === 1'b1);
            lc = lc | ~ctrl_o;
            ls = ls | ~sel_o;
            ld = ld | ~sd_o;
        end
        core_req <= '0;
        chk(nd, 1);
        chk({lc & ~ic, ls & ~is, ld & 4'hd}, {ec, es, ed});
    endtask
    // hang guard: the whole run needs far fewer cycles than this
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (43) @(posedge clk);
        chk({cke, stall}, 2'b01);
        self_want <= 1'b0;
        repeat (40) @(posedge clk);
        chk({cke, stall}, 2'b10);
        wb(0, ebs_pkg::EBS_ADDR_CTRL_FN, 0);
        chk(q, 0);
        wb(1, ebs_pkg::EBS_ADDR_SEL_DIR, 32'h3ff);
        wb(1, ebs_pkg::EBS_ADDR_PORT_DATA, 32'h0155_0000);
        repeat (3) @(posedge clk);
        chk({sel_o, sel_oe}, 20'h557ff);
        wb(1, ebs_pkg::EBS_ADDR_CTRL_FN, 32'hffff);
        wb(1, ebs_pkg::EBS_ADDR_SEL_FN, 32'h3ff);
        wb(1, ebs_pkg::EBS_ADDR_SD_FN, 32'hf);
        wb(0, ebs_pkg::EBS_ADDR_SEL_FN, 0);
        chk(q, 32'h3ff);
        wb(0, 8'h40, 0);
        chk(q, 0);
        bus('{1'b1, 1'b1, ebs_pkg::EBS_AREA_SRAM, 3'h3, 4'h5, 1'b0},
            16'ha055, 16'h0000, 10'h108, 10'h0, 4'h0);
        bus('{1'b1, 1'b0, ebs_pkg::EBS_AREA_PAGEROM, 3'h5, 4'hf, 1'b0},
            16'h90f0, 16'h0000, 10'h020, 10'h0, 4'h0);
        bus('{1'b1, 1'b1, ebs_pkg::EBS_AREA_IO, 3'h2, 4'hf, 1'b1},
            16'ha0ff, 16'h0000, 10'h104, 10'h0, 4'h0);
        bus('{1'b1, 1'b1, ebs_pkg::EBS_AREA_SDRAM, 3'h0, 4'h1, 1'b0},
            16'hce10, 16'h0000, 10'h000, 10'h000, 4'hc);
        wb(1, ebs_pkg::EBS_ADDR_BCP, 32'h1);
        bus('{1'b1, 1'b0, ebs_pkg::EBS_AREA_ROM, 3'h1, 4'h3, 1'b0},
            16'h9030, 16'h0000, 10'h202, 10'h0, 4'h0);
        standby <= 1'b1;
        repeat (6) @(posedge clk);
        chk(cke, 0);
        standby <= 1'b0;
        hold_want <= 1'b1;
        @(posedge clk);
        while (hack !== 1'b1) @(posedge clk);
        repeat (3) @(posedge clk);
        chk({ctrl_oe, sel_oe, sd_oe}, 30'h3);
        irq_ref <= 1'b1;
        @(posedge clk);
        irq_ref <= 1'b0;
        repeat (4) @(posedge clk);
        chk(rr, 0);
        hold_want <= 1'b0;
        while (hack !== 1'b0) @(posedge clk);
        rl = 1'b0;
        sdl = 4'h0;
        repeat (80) begin
            @(posedge clk);
            rl = rl | ~rr;
            sdl = sdl | ~sd_o;
        end
        chk({rl, sdl, rr}, 6'h3d);
        tally_and_finish;
    end
endmodule
